/* dac_link_pkg.sv */
// constants and types shared by the converter front end
package dac_link_pkg;

  // ==========================================
  // code word
  localparam int CODE_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [15:0] RESET_CODE_MID = 16'h8000;
  localparam logic [15:0] RESET_CODE_ZERO = 16'h0000;
  localparam logic [15:0] TWOS_FLIP = 16'h8000;

  // ==========================================
  // pin synchroniser lanes
  localparam int PIN_W = 9;
  localparam int IDX_SCLK = 0;
  localparam int IDX_SDI = 1;
  localparam int IDX_CS_N = 2;
  localparam int IDX_LOAD_N = 3;
  localparam int IDX_RESET_N = 4;
  localparam int IDX_PDOWN = 5;
  localparam int IDX_RSEL = 6;
  localparam int IDX_FMT = 7;
  localparam int IDX_OSEL = 8;
  // idle levels: clock, power-down and selects low, active-low pins high
  localparam logic [8:0] PIN_RESET_VAL = 9'h01C;

  // ==========================================
  // cycles until the synchronised straps are trustworthy after reset
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  typedef enum logic {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_e;

endpackage : dac_link_pkg

/* dac_serial_input_latch_control.sv */
// serial input, input register and load latch of a 16-bit converter
// Operation
// R01 - Serial bits enter the shift register only while chip select is held low.
// R02 - The serial output is driven only while selected and released while chip select is high.
// R03 - While the load input is low the latch is transparent and follows the input register.
// R04 - The converter code moves in the same cycle as the latch takes its new value.
// R05 - After reset the registers hold 8000h with reset select high and 0000h with it low.
// R06 - A low on the reset pin resets the device back to the selected reset code.
// R07 - While power-down is high the output is held grounded.
// R08 - Codes are straight binary with format select high and two's complement with it low.
// R09 - With output select high the input register is shifted out on the serial output.
// R10 - With output select low the shift register is shifted out for a cascaded device.
// R11 - Each serial output bit changes after a falling serial clock edge. The code presents the first bit when chip select falls.
// R12 - A transfer is 16 bits MSB first, moved to the input register when chip select rises.
// R13 - The host pulses the load input low after chip select rises unless it is tied low.
`timescale 1ns/1ps
module dac_serial_input_latch_control (
  // system clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // serial link pins
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic CS_N,
  output logic SDO,
  output logic SDO_OE,
  // static and control pins
  input wire logic LOAD_LATCH_N,
  input wire logic RESET_N,
  input wire logic POWER_DOWN,
  input wire logic RESET_CODE_SELECT,
  input wire logic FORMAT_SELECT,
  input wire logic SERIAL_OUT_SOURCE_SELECT,
  // converter side
  output logic [dac_link_pkg::CODE_W-1:0] DAC_CODE,
  output logic [dac_link_pkg::CODE_W-1:0] INPUT_CODE,
  output logic OUT_GROUNDED
);
  import dac_link_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    link_state_e state;
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] bit_cnt;
    logic [CODE_W-1:0] shift_reg;
    logic [CODE_W-1:0] out_shift;
    logic [CODE_W-1:0] input_code;
    logic [CODE_W-1:0] latch_code;
    logic [CODE_W-1:0] dac_code;
    logic sdo;
    logic sdo_oe;
    logic grounded;
    logic [2:0] settle;
  } ctl_s;

  ctl_s st_reg;
  ctl_s st_next;

  // ==========================================
  // functions
  function automatic logic [CODE_W-1:0] fmt_code(input logic [CODE_W-1:0] code,
                                                 input logic straight);
    // two's complement is moved onto the offset-binary scale of the converter
    fmt_code = straight ? code : (code ^ TWOS_FLIP);
  endfunction : fmt_code

  function automatic logic [CODE_W-1:0] reset_code(input logic sel);
    reset_code = sel ? RESET_CODE_MID : RESET_CODE_ZERO;
  endfunction : reset_code

  // ==========================================
  // pin synchronisation
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] lvl;

  assign pins = {SERIAL_OUT_SOURCE_SELECT, FORMAT_SELECT, RESET_CODE_SELECT, POWER_DOWN,
                 RESET_N, LOAD_LATCH_N, CS_N, SDI, SCLK};

  pin_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RESET_VAL)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pins(pins),
    .level(lvl)
  );

  logic sclk_f;
  logic sdi_f;
  logic cs_f;
  logic load_n_f;
  logic hw_rst_n_f;
  logic pdown_f;
  logic rsel_f;
  logic fmt_f;
  logic osel_f;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic in_reset;

  assign sclk_f = lvl[IDX_SCLK];
  assign sdi_f = lvl[IDX_SDI];
  assign cs_f = lvl[IDX_CS_N];
  assign load_n_f = lvl[IDX_LOAD_N];
  assign hw_rst_n_f = lvl[IDX_RESET_N];
  assign pdown_f = lvl[IDX_PDOWN];
  assign rsel_f = lvl[IDX_RSEL];
  assign fmt_f = lvl[IDX_FMT];
  assign osel_f = lvl[IDX_OSEL];
  assign sclk_rise = sclk_f & ~st_reg.sclk_prev;
  assign sclk_fall = ~sclk_f & st_reg.sclk_prev;
  assign cs_fall = ~cs_f & st_reg.cs_prev;
  assign cs_rise = cs_f & ~st_reg.cs_prev;
  // filter output holds the straps only from settle == SETTLE_CYCLES, so reload once more
  localparam logic [2:0] SETTLE_END = SETTLE_CYCLES + 3'h1;
  assign in_reset = ~hw_rst_n_f | (st_reg.settle != SETTLE_END);

  // ==========================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sclk_prev = sclk_f;
    st_next.cs_prev = cs_f;
    st_next.grounded = pdown_f; // [R07]
    if (st_reg.settle != SETTLE_END)
    begin
      st_next.settle = st_reg.settle + 3'h1;
    end
    if (in_reset)
    begin
      // reset pin low or settling: shift, output shift, input and latch codes back to the strap value
      st_next.state = LINK_IDLE;
      st_next.bit_cnt = '0;
      st_next.shift_reg = reset_code(rsel_f); // [R05] [R06]
      st_next.out_shift = reset_code(rsel_f);
      st_next.input_code = reset_code(rsel_f); // [R05] [R06]
      st_next.latch_code = reset_code(rsel_f); // [R05] [R06]
      st_next.sdo = 1'b0;
      st_next.sdo_oe = 1'b0;
    end
    else
    begin
      unique case (st_reg.state)
        LINK_IDLE:
        begin
          if (cs_fall)
          begin
            st_next.state = LINK_SHIFT;
            st_next.bit_cnt = '0;
            st_next.out_shift = st_reg.input_code;
            st_next.sdo_oe = 1'b1; // [R02]
            // first bit is presented at select, ahead of the first rising edge
            st_next.sdo = osel_f ? st_reg.input_code[CODE_W-1]
                                 : st_reg.shift_reg[CODE_W-1]; // [R09] [R10]
          end
        end
        LINK_SHIFT:
        begin
          if (cs_f)
          begin
            st_next.state = LINK_IDLE;
            st_next.sdo_oe = 1'b0; // [R02]
            st_next.sdo = 1'b0;
            // a short word is dropped; a long one keeps its last 16 bits
            if (st_reg.bit_cnt >= WORD_BITS)
            begin
              st_next.input_code = st_reg.shift_reg; // [R12]
            end
          end
          else if (sclk_rise)
          begin
            st_next.shift_reg = {st_reg.shift_reg[CODE_W-2:0], sdi_f}; // [R01] [R12]
            st_next.out_shift = {st_reg.out_shift[CODE_W-2:0], 1'b0};
            if (st_reg.bit_cnt < WORD_BITS)
            begin
              st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            end
          end
          else if (sclk_fall)
          begin
            st_next.sdo = osel_f ? st_reg.out_shift[CODE_W-1]
                                 : st_reg.shift_reg[CODE_W-1]; // [R09] [R10] [R11]
          end
        end
      endcase
      // host pulses load low after the word lands, or ties it low
      if (!load_n_f)
      begin
        st_next.latch_code = st_next.input_code; // [R03] [R13]
      end
    end
    st_next.dac_code = fmt_code(st_next.latch_code, fmt_f); // [R04] [R08]
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      st_reg <= '{state: LINK_IDLE, sclk_prev: 1'b0, cs_prev: 1'b1, bit_cnt: 5'h00,
                  shift_reg: RESET_CODE_ZERO, out_shift: RESET_CODE_ZERO,
                  input_code: RESET_CODE_ZERO, latch_code: RESET_CODE_ZERO,
                  dac_code: RESET_CODE_ZERO, sdo: 1'b0, sdo_oe: 1'b0, grounded: 1'b0,
                  settle: 3'h0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // outputs
  assign SDO = st_reg.sdo;
  assign SDO_OE = st_reg.sdo_oe;
  assign DAC_CODE = st_reg.dac_code;
  assign INPUT_CODE = st_reg.input_code;
  assign OUT_GROUNDED = st_reg.grounded;

  // ==========================================
  // assertions
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  sequence seq_live;
    !in_reset;
  endsequence

  sequence seq_word_done;
    seq_live ##0 (st_reg.state == LINK_SHIFT) && cs_f && (st_reg.bit_cnt >= WORD_BITS);
  endsequence

  sequence seq_deselected;
    seq_live ##0 cs_f && st_reg.cs_prev;
  endsequence

  AST_NO_SHIFT_DESELECTED: assert property ( // [R01]
    seq_deselected |=> $stable(st_reg.shift_reg))
    else $error("shift register moved while deselected");

  AST_SDO_RELEASED: assert property ( // [R02]
    cs_f ##1 cs_f |-> !SDO_OE)
    else $error("serial output driven while deselected");

  AST_SDO_DRIVEN: assert property ( // [R02]
    (seq_live ##0 cs_fall && st_reg.state == LINK_IDLE) |=> SDO_OE [*1] ##1 (SDO_OE || cs_f))
    else $error("serial output not driven after select");

  AST_LATCH_TRANSPARENT: assert property ( // [R03]
    (seq_live ##0 !load_n_f) |=> (st_reg.latch_code == INPUT_CODE))
    else $error("latch did not follow input register");

  AST_CODE_WITH_LATCH: assert property ( // [R04]
    $changed(st_reg.latch_code) |-> (DAC_CODE == fmt_code(st_reg.latch_code, $past(fmt_f))))
    else $error("converter code lags the latch");

  AST_RESET_CODE: assert property ( // [R05]
    (!hw_rst_n_f) |=> (INPUT_CODE == reset_code($past(rsel_f)))
                      && (st_reg.latch_code == INPUT_CODE))
    else $error("wrong code after reset");

  AST_POWER_DOWN: assert property ( // [R07]
    pdown_f ##1 pdown_f |-> OUT_GROUNDED)
    else $error("output not grounded in power-down");

  AST_SDO_SOURCE: assert property ( // [R09]
    (seq_live ##0 st_reg.state == LINK_SHIFT && !cs_f && sclk_fall)
      |=> (SDO == ($past(osel_f) ? $past(st_reg.out_shift[CODE_W-1])
                                 : $past(st_reg.shift_reg[CODE_W-1]))))
    else $error("serial output took the wrong source bit");

  AST_SDO_ON_FALL: assert property ( // [R11]
    $changed(SDO) && SDO_OE && $past(SDO_OE) |-> $past(sclk_fall))
    else $error("serial output changed away from a falling edge");

  AST_WORD_LOADED: assert property ( // [R12]
    seq_word_done |=> (INPUT_CODE == $past(st_reg.shift_reg)))
    else $error("completed word not moved to input register");

  AST_SHORT_WORD_DROPPED: assert property ( // [R12]
    (seq_live ##0 st_reg.state == LINK_SHIFT && cs_f && st_reg.bit_cnt < WORD_BITS)
      |=> $stable(INPUT_CODE))
    else $error("short word reached the input register");

  AST_GROUND_RELEASED: assert property ( // [R07]
    !pdown_f ##1 !pdown_f |-> !OUT_GROUNDED)
    else $error("output grounded outside power-down");

  AST_RESET_RELEASES_SDO: assert property ( // [R06]
    (!hw_rst_n_f) |=> !SDO_OE)
    else $error("serial output driven during device reset");

endmodule : dac_serial_input_latch_control

/* dac_serial_input_latch_control_tb.sv */
// self-checking bench for the converter serial front end
`timescale 1ns/1ps
module dac_serial_input_latch_control_tb;
  import dac_link_pkg::*;

  typedef struct packed {
    logic [15:0] word;
    logic fmt;
    logic osel;
    logic [15:0] dac;
  } row_s;

  // ==========================================
  // stimulus and observation
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic load_latch_n = 1'b1;
  logic reset_n = 1'b1;
  logic power_down = 1'b0;
  logic reset_code_select = 1'b1;
  logic format_select = 1'b1;
  logic serial_out_source_select = 1'b1;
  logic sclk;
  logic sdi;
  logic cs_n;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;
  logic [15:0] dac_code;
  logic [15:0] input_code;
  logic out_grounded;
  logic [23:0] rx;
  logic [15:0] prev;
  logic [15:0] latch;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // word, format strap, output source strap, converter code expected after the load
  row_s rows [6] = '{'{16'h1234, 1'b1, 1'b1, 16'h1234}, '{16'hABCD, 1'b0, 1'b1, 16'h2BCD},
                     '{16'hFFFF, 1'b1, 1'b0, 16'hFFFF}, '{16'h0001, 1'b0, 1'b0, 16'h8001},
                     '{16'h8000, 1'b1, 1'b1, 16'h8000}, '{16'h7FFF, 1'b0, 1'b0, 16'hFFFF}};

  always #25 clk_sys = ~clk_sys;

  // released line shows the opposite level so a missing enable cannot pass
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  dac_serial_input_latch_control u_dac_serial_input_latch_control (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SCLK(sclk), .SDI(sdi), .CS_N(cs_n), .SDO(sdo),
    .SDO_OE(sdo_oe), .LOAD_LATCH_N(load_latch_n), .RESET_N(reset_n), .POWER_DOWN(power_down),
    .RESET_CODE_SELECT(reset_code_select), .FORMAT_SELECT(format_select),
    .SERIAL_OUT_SOURCE_SELECT(serial_out_source_select), .DAC_CODE(dac_code),
    .INPUT_CODE(input_code), .OUT_GROUNDED(out_grounded)
  );

  spi_host_model u_spi_host_model (.sdo_line(sdo_line), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));

  // ==========================================
  // helpers
  function automatic logic [15:0] fmt_code(input logic [15:0] w, input logic f);
    return f ? w : w ^ TWOS_FLIP;
  endfunction : fmt_code

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse_load();
    load_latch_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    load_latch_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : pulse_load

  task automatic final_report();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ==========================================
  // hang guard, well above the roughly 1500 cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check(input_code, RESET_CODE_MID);
    check(dac_code, RESET_CODE_MID);
    prev = RESET_CODE_MID;
    latch = RESET_CODE_MID;
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      format_select <= rows[i].fmt;
      serial_out_source_select <= rows[i].osel;
      u_spi_host_model.xfer({8'h00, rows[i].word}, 16, rx);
      repeat (8) @(posedge clk_sys);
      check(rx[15:0], prev);
      check(input_code, rows[i].word);
      check({15'h0000, sdo_oe}, 16'h0000);
      check(dac_code, fmt_code(latch, rows[i].fmt));
      pulse_load();
      check(dac_code, rows[i].dac);
      prev = rows[i].word;
      latch = rows[i].word;
    end
    // short frame dropped, long frame keeps its last 16 bits
    @(posedge clk_sys);
    serial_out_source_select <= 1'b1;
    u_spi_host_model.xfer(24'h00005A, 8, rx);
    repeat (8) @(posedge clk_sys);
    check(input_code, prev);
    // stand-alone shows the input register, not the bits just shifted in
    check({8'h00, rx[7:0]}, {8'h00, prev[15:8]});
    serial_out_source_select <= 1'b0;
    u_spi_host_model.xfer(24'hABC123, 24, rx);
    repeat (8) @(posedge clk_sys);
    check(rx[23:8], {prev[7:0], 8'h5A});
    check({8'h00, rx[7:0]}, 16'h00AB);
    check(input_code, 16'hC123);
    // load held low: latch follows the new word directly
    load_latch_n <= 1'b0;
    u_spi_host_model.xfer(24'h002468, 16, rx);
    repeat (8) @(posedge clk_sys);
    check(dac_code, fmt_code(16'h2468, 1'b0));
    load_latch_n <= 1'b1;
    power_down <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check({15'h0000, out_grounded}, 16'h0001);
    check(dac_code, 16'hA468);
    power_down <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check({15'h0000, out_grounded}, 16'h0000);
    reset_code_select <= 1'b0;
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check(input_code, RESET_CODE_ZERO);
    check(dac_code, fmt_code(RESET_CODE_ZERO, 1'b0));
    final_report();
  end
endmodule : dac_serial_input_latch_control_tb

/* pin_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] flt;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;
  logic [WIDTH-1:0] differ;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change is taken only once stages two and three agree
    differ = st_reg.s2 ^ st_reg.s3;
    st_next.flt = (~differ & st_reg.s3) | (differ & st_reg.flt);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.flt;

endmodule : pin_sync

/* spi_host_model.sv */
// host link model driving the converter serial pins
`timescale 1ns/1ps
module spi_host_model (
  // converter serial output as resolved on the wire
  input wire logic sdo_line,
  // link pins driven by the host
  output logic sclk,
  output logic sdi,
  output logic cs_n
);
  // ==========================================
  // 400 ns link clock, parked low between frames
  localparam int HALF = 200;

  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end

  task automatic xfer(input logic [23:0] data, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    // odd offset keeps the link out of phase with the system clock
    #13;
    cs_n = 1'b0;
    #(2 * HALF);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdi = data[i];
      #HALF;
      sclk = 1'b1;
      // sample late in the high phase: the output trails the pins by the synchroniser
      #(HALF - 10);
      rx = {rx[22:0], sdo_line};
      #10;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    sdi = ~sdi;
    #(2 * HALF);
  endtask : xfer
endmodule : spi_host_model
